/* File: serial_port_ctrl.sv */
// Top of the synchronous serial port: settings, clocking, line state and framing.
`timescale 1ns/10ps
`include "serial_port_params.svh"
module serial_port_ctrl (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire logic role_dce,
   input serial_port_pkg::clk_mode_t clock_mode,
   input serial_port_pkg::l2_mode_t l2_mode,
   input wire logic line_check_en,
   input wire logic [22:0] rate_bps,
   input wire logic rate_load,
   input wire logic ind_i,
   input wire logic rxd_i,
   output logic bclk_o,
   output logic bclk_oe,
   output logic txd_o,
   input wire logic tx_valid,
   input serial_port_pkg::tx_word_t tx_word,
   output logic tx_ready,
   output logic tx_busy,
   output logic rx_valid,
   output serial_port_pkg::rx_word_t rx_word,
   output logic [22:0] active_rate,
   output logic rate_reject,
   output logic line_up_flag,
   output logic link_ready
);
   // System-domain state.
   logic [22:0] rate_q, rate_d;
   logic reject_q, reject_d;
   logic drive_q, drive_d;
   logic [2:0] ind_s_q;
   logic ind_f_q, ind_f_d;
   logic line_up_q, line_up_d;
   serial_port_pkg::seq_state_t seq_q, seq_d;
   serial_port_pkg::tx_word_t xfer_q, xfer_d;
   logic req_q, req_d, run_q, run_d;
   logic rx_seen_q, rx_seen_d, rx_valid_q, rx_valid_d;
   serial_port_pkg::rx_word_t rx_word_q, rx_word_d;
   logic [2:0] ls1_q, ls2_q, ls3_q, lf_q;
   logic busy, link_ok;

   // Link-domain state.
   logic [2:0] ks1_q, ks2_q, ks3_q, kf_q;
   logic link_rst_n, echo_q, ack_tog;
   logic [2:0] ones_q, ones_d, cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, held_q, held_d;
   logic held_v_q, held_v_d, in_frame_q, in_frame_d;
   logic rx_tog_q, rx_tog_d;
   serial_port_pkg::rx_word_t rx_out_q, rx_out_d;

   // Address byte for command frames, chosen from the layer-2 mode and role.
   function automatic logic [7:0] frame_addr(input serial_port_pkg::l2_mode_t m,
                                             input logic dce);
      case (m)
         serial_port_pkg::L2_DTE: frame_addr = `ADDR_DTE;
         serial_port_pkg::L2_DCE: frame_addr = `ADDR_DCE;
         default: frame_addr = dce ? `ADDR_DCE : `ADDR_DTE;
      endcase
   endfunction : frame_addr

   // Settings: a rate outside the legal span is refused and the old rate kept.
   always_comb begin
      rate_d = rate_q;
      reject_d = 1'b0;
      if (rate_load) begin
         if (rate_bps >= `RATE_MIN && rate_bps <= `RATE_MAX) begin
            rate_d = rate_bps;
         end else begin
            reject_d = 1'b1;
         end
      end
      case (clock_mode)
         serial_port_pkg::CLK_AUTO: drive_d = role_dce;
         serial_port_pkg::CLK_EXTERNAL: drive_d = 1'b0;
         serial_port_pkg::CLK_INTERNAL: drive_d = 1'b1;
         default: drive_d = 1'b0;
      endcase
   end

   // Indication line: three stages, accepted once the last two agree.
   always_comb begin
      ind_f_d = (ind_s_q[1] == ind_s_q[2]) ? ind_s_q[2] : ind_f_q;
      line_up_d = line_check_en ? ind_f_q : 1'b1;
   end

   // Registers only.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rate_q <= `RATE_DEF;
         reject_q <= 1'b0;
         drive_q <= 1'b0;
         ind_s_q <= 3'h0;
         ind_f_q <= 1'b0;
         line_up_q <= 1'b1;
      end else begin
         rate_q <= rate_d;
         reject_q <= reject_d;
         drive_q <= drive_d;
         ind_s_q <= {ind_s_q[1:0], ind_i};
         ind_f_q <= ind_f_d;
         line_up_q <= line_up_d;
      end
   end

   // The generator runs only while this end owns the clock pin.
   bit_clock_gen u_gen (
      .clk(clk),
      .reset_n(reset_n),
      .enable(drive_q),
      .rate(rate_q),
      .bclk_o(bclk_o)
   );

   // The link is usable once it has shown it saw the run request low and then high.
   assign busy = req_q != lf_q[0];
   assign link_ok = run_q & lf_q[2];

   // Frame sequencer: the address word goes first, then the user words.
   always_comb begin
      seq_d = seq_q;
      xfer_d = xfer_q;
      req_d = req_q;
      run_d = run_q;
      rx_seen_d = rx_seen_q;
      rx_word_d = rx_word_q;
      rx_valid_d = 1'b0;
      if (lf_q[2] == 1'b0) begin
         run_d = 1'b1;
      end
      case (seq_q)
         serial_port_pkg::SEQ_IDLE: begin
            if (tx_valid && link_ok && !busy) begin
               xfer_d.last = 1'b0;
               xfer_d.data = frame_addr(l2_mode, role_dce);
               req_d = ~req_q;
               seq_d = serial_port_pkg::SEQ_BODY;
            end
         end
         serial_port_pkg::SEQ_BODY: begin
            if (tx_valid && link_ok && !busy) begin
               xfer_d = tx_word;
               req_d = ~req_q;
               if (tx_word.last) begin
                  seq_d = serial_port_pkg::SEQ_IDLE;
               end
            end
         end
         default: seq_d = serial_port_pkg::SEQ_IDLE;
      endcase
      if (link_ok && (lf_q[1] != rx_seen_q)) begin
         rx_seen_d = lf_q[1];
         rx_word_d = rx_out_q; // Stable for a whole byte time after its toggle.
         rx_valid_d = 1'b1;
      end
   end

   // Registers only; the crossing stages are not reset so a stale reply cannot pass.
   always_ff @(posedge clk) begin
      ls1_q <= {echo_q, rx_tog_q, ack_tog};
      ls2_q <= ls1_q;
      ls3_q <= ls2_q;
      lf_q <= serial_port_pkg::agree_filter(ls2_q, ls3_q, lf_q);
      if (!reset_n) begin
         seq_q <= serial_port_pkg::SEQ_IDLE;
         xfer_q <= '0;
         req_q <= 1'b0;
         run_q <= 1'b0;
         rx_seen_q <= 1'b0;
         rx_word_q <= '0;
         rx_valid_q <= 1'b0;
      end else begin
         seq_q <= seq_d;
         xfer_q <= xfer_d;
         req_q <= req_d;
         run_q <= run_d;
         rx_seen_q <= rx_seen_d;
         rx_word_q <= rx_word_d;
         rx_valid_q <= rx_valid_d;
      end
   end

   // Run request and word request into the link domain.
   always_ff @(posedge link_clk) begin
      ks1_q <= {1'b0, run_q, req_q};
      ks2_q <= ks1_q;
      ks3_q <= ks2_q;
      kf_q <= serial_port_pkg::agree_filter(ks2_q, ks3_q, kf_q);
      echo_q <= kf_q[1];
   end

   assign link_rst_n = kf_q[1];

   tx_serializer u_ser (
      .link_clk(link_clk),
      .link_rst_n(link_rst_n),
      .req_level(kf_q[0]),
      .word(xfer_q),
      .ack_o(ack_tog),
      .txd_o(txd_o)
   );

   // Receive deframer on the bit clock: flag hunt, destuffing, one byte held back
   // so the byte before a closing flag can be marked as the frame's end.
   always_comb begin
      ones_d = ones_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      held_d = held_q;
      held_v_d = held_v_q;
      in_frame_d = in_frame_q;
      rx_tog_d = rx_tog_q;
      rx_out_d = rx_out_q;
      if (rxd_i) begin
         ones_d = (ones_q == `ABORT_RUN) ? `ABORT_RUN : ones_q + 3'h1;
         if (ones_d == `ABORT_RUN) begin
            in_frame_d = 1'b0;
            held_v_d = 1'b0;
         end
      end else begin
         ones_d = 3'h0;
      end
      if (!rxd_i && ones_q == `FLAG_RUN) begin
         if (in_frame_q && held_v_q) begin
            rx_out_d.eof = 1'b1;
            rx_out_d.data = held_q;
            rx_tog_d = ~rx_tog_q;
         end
         in_frame_d = 1'b1;
         held_v_d = 1'b0;
         cnt_d = 3'h0;
      end else if (!(!rxd_i && ones_q == `STUFF_RUN) && ones_d != `ABORT_RUN) begin
         sh_d = {rxd_i, sh_q[7:1]};
         cnt_d = cnt_q + 3'h1;
         if (cnt_q == `BIT_LAST && in_frame_q) begin
            if (held_v_q) begin
               rx_out_d.eof = 1'b0;
               rx_out_d.data = held_q;
               rx_tog_d = ~rx_tog_q;
            end
            held_d = sh_d;
            held_v_d = 1'b1;
         end
      end
   end

   // Registers only.
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         ones_q <= 3'h0;
         cnt_q <= 3'h0;
         sh_q <= 8'h00;
         held_q <= 8'h00;
         held_v_q <= 1'b0;
         in_frame_q <= 1'b0;
         rx_tog_q <= 1'b0;
         rx_out_q <= '0;
      end else begin
         ones_q <= ones_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         held_q <= held_d;
         held_v_q <= held_v_d;
         in_frame_q <= in_frame_d;
         rx_tog_q <= rx_tog_d;
         rx_out_q <= rx_out_d;
      end
   end

   // Outputs.
   assign bclk_oe = drive_q;
   assign tx_ready = (seq_q == serial_port_pkg::SEQ_BODY) && link_ok && !busy;
   assign tx_busy = (seq_q == serial_port_pkg::SEQ_BODY) || busy;
   assign rx_valid = rx_valid_q;
   assign rx_word = rx_word_q;
   assign active_rate = rate_q;
   assign rate_reject = reject_q;
   assign line_up_flag = line_up_q;
   assign link_ready = link_ok;
endmodule : serial_port_ctrl

/* File: serial_port_params.svh */
// Constants for the synchronous serial port control block.
// Summary of operation
// - Auto clock mode drives the bit clock as DCE and takes it from the partner as DTE.
// - External clock mode always takes the partner's bit clock, whatever the role.
// - Internal clock mode always generates and drives the bit clock, whatever the role.
// - The line rate is loadable from 2400 bps to 8 Mbps and is 64000 bps after reset.
// - Auto layer-2 mode sends address 0x01 as DTE and 0x03 as DCE in command frames.
// - Forced DTE layer-2 mode sends address 0x01 and forced DCE sends 0x03, whatever the role.
// - With line checking on, the partner's indication line is sampled into line_up_flag.
// - With line checking off, the indication line is ignored and line_up_flag stays high.
// - The role input picks DTE (low, the default) or DCE, and auto modes follow it.
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH
`define SYS_CLK_HZ 26'h17d7840
`define RATE_MIN 23'h000960
`define RATE_MAX 23'h7a1200
`define RATE_DEF 23'h00fa00
`define ADDR_DTE 8'h01
`define ADDR_DCE 8'h03
`define HDLC_FLAG 8'h7e
`define STUFF_RUN 3'h5
`define FLAG_RUN 3'h6
`define ABORT_RUN 3'h7
`define BIT_LAST 3'h7
`endif

/* File: serial_port_pkg.sv */
// Types shared by the serial port control block.
package serial_port_pkg;
   typedef enum logic [1:0] {CLK_AUTO, CLK_EXTERNAL, CLK_INTERNAL} clk_mode_t;
   typedef enum logic [1:0] {L2_AUTO, L2_DTE, L2_DCE} l2_mode_t;
   typedef enum logic {SEQ_IDLE, SEQ_BODY} seq_state_t;
   typedef enum logic [1:0] {SER_IDLE, SER_FLAG, SER_DATA} ser_state_t;

   typedef struct packed {
      logic last;
      logic [7:0] data;
   } tx_word_t;

   typedef struct packed {
      logic eof;
      logic [7:0] data;
   } rx_word_t;

   // A crossed level changes only once the second and third stages agree.
   function automatic logic [2:0] agree_filter(input logic [2:0] s2,
                                               input logic [2:0] s3,
                                               input logic [2:0] f);
      agree_filter = (s2 & s3) | (f & (s2 ^ s3));
   endfunction : agree_filter
endpackage : serial_port_pkg

/* File: bit_clock_gen.sv */
// Bit clock generator: phase accumulator that toggles at twice the line rate.
`timescale 1ns/10ps
`include "serial_port_params.svh"
module bit_clock_gen (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic [22:0] rate,
   output logic bclk_o
);
   logic [25:0] acc_q, acc_d;
   logic bclk_q, bclk_d;
   logic [25:0] sum;

   // Adds twice the rate each cycle; every wrap of the system frequency is one half period.
   // Edges land on system clock edges, so high rates carry up to one cycle of jitter.
   always_comb begin
      sum = acc_q + {2'h0, rate, 1'b0};
      acc_d = sum;
      bclk_d = bclk_q;
      if (!enable) begin
         acc_d = 26'h0000000;
         bclk_d = 1'b0;
      end else if (sum >= `SYS_CLK_HZ) begin
         acc_d = sum - `SYS_CLK_HZ;
         bclk_d = ~bclk_q;
      end
   end

   // Registers only.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         acc_q <= 26'h0000000;
         bclk_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         bclk_q <= bclk_d;
      end
   end

   assign bclk_o = bclk_q;
endmodule : bit_clock_gen

/* File: tx_serializer.sv */
// Link-side HDLC transmitter: flags, zero-bit stuffing, one word of look-ahead.
`timescale 1ns/10ps
`include "serial_port_params.svh"
module tx_serializer (
   input wire logic link_clk,
   input wire logic link_rst_n,
   input wire logic req_level,
   input serial_port_pkg::tx_word_t word,
   output logic ack_o,
   output logic txd_o
);
   serial_port_pkg::ser_state_t st_q, st_d;
   serial_port_pkg::tx_word_t hold_q, hold_d;
   logic hold_v_q, hold_v_d, ack_q, ack_d;
   logic [7:0] sh_q, sh_d;
   logic [2:0] cnt_q, cnt_d, ones_q, ones_d;
   logic last_q, last_d, close_q, close_d, bit_q, bit_d;
   logic use_hold, txd_q;

   // Bits advance on the bit clock only; an empty look-ahead mid-frame closes it early.
   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      ones_d = ones_q;
      last_d = last_q;
      close_d = close_q;
      bit_d = 1'b1;
      use_hold = 1'b0;
      case (st_q)
         serial_port_pkg::SER_IDLE: begin
            if (hold_v_q) begin
               st_d = serial_port_pkg::SER_FLAG;
               cnt_d = 3'h0;
               ones_d = 3'h0;
               close_d = 1'b0;
            end
         end
         serial_port_pkg::SER_FLAG: begin
            if (ones_q == `STUFF_RUN) begin
               bit_d = 1'b0; // Stuffed zero owed by the last data byte.
               ones_d = 3'h0;
            end else begin
               bit_d = 1'(`HDLC_FLAG >> cnt_q); // Only the bit at the current position is sent.
               cnt_d = cnt_q + 3'h1;
               if (cnt_q == `BIT_LAST) begin
                  ones_d = 3'h0;
                  if (close_q) begin
                     st_d = serial_port_pkg::SER_IDLE;
                  end else begin
                     st_d = serial_port_pkg::SER_DATA;
                     sh_d = hold_q.data;
                     last_d = hold_q.last;
                     use_hold = 1'b1;
                  end
               end
            end
         end
         serial_port_pkg::SER_DATA: begin
            if (ones_q == `STUFF_RUN) begin
               bit_d = 1'b0;
               ones_d = 3'h0;
            end else begin
               bit_d = sh_q[0];
               sh_d = {1'b0, sh_q[7:1]};
               ones_d = sh_q[0] ? ones_q + 3'h1 : 3'h0;
               cnt_d = cnt_q + 3'h1;
               if (cnt_q == `BIT_LAST) begin
                  if (!last_q && hold_v_q) begin
                     sh_d = hold_q.data;
                     last_d = hold_q.last;
                     use_hold = 1'b1;
                  end else begin
                     st_d = serial_port_pkg::SER_FLAG;
                     close_d = 1'b1;
                  end
               end
            end
         end
         default: st_d = serial_port_pkg::SER_IDLE;
      endcase
      hold_d = hold_q;
      hold_v_d = hold_v_q & ~use_hold;
      ack_d = ack_q;
      if ((req_level != ack_q) && !hold_v_q) begin
         hold_d = word;
         hold_v_d = 1'b1;
         ack_d = ~ack_q;
      end
   end

   // Registers only.
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         st_q <= serial_port_pkg::SER_IDLE;
         hold_q <= '0;
         hold_v_q <= 1'b0;
         ack_q <= 1'b0;
         sh_q <= 8'h00;
         cnt_q <= 3'h0;
         ones_q <= 3'h0;
         last_q <= 1'b0;
         close_q <= 1'b0;
         bit_q <= 1'b1;
      end else begin
         st_q <= st_d;
         hold_q <= hold_d;
         hold_v_q <= hold_v_d;
         ack_q <= ack_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         ones_q <= ones_d;
         last_q <= last_d;
         close_q <= close_d;
         bit_q <= bit_d;
      end
   end

   // Launch on the falling edge so the partner samples mid-bit on the rising edge.
   always_ff @(negedge link_clk) begin
      if (!link_rst_n) begin
         txd_q <= 1'b1;
      end else begin
         txd_q <= bit_q;
      end
   end

   assign ack_o = ack_q;
   assign txd_o = txd_q;
endmodule : tx_serializer

/* File: serial_port_ctrl_assertions.sv */
// Concurrent checks on the serial port control block's settings and status outputs.
`timescale 1ns/10ps
`include "serial_port_params.svh"
module serial_port_ctrl_assertions (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic role_dce,
   input serial_port_pkg::clk_mode_t clock_mode,
   input wire logic line_check_en,
   input wire logic [22:0] rate_bps,
   input wire logic rate_load,
   input wire logic ind_i,
   input wire logic bclk_o,
   input wire logic bclk_oe,
   input wire logic [22:0] active_rate,
   input wire logic rate_reject,
   input wire logic line_up_flag
);
   logic want_oe_d;
   logic want_oe_q;
   logic rate_ok;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Expected pin drive; gated by reset so the first edge after release cannot misfire.
   always_comb begin
      want_oe_d = reset_n & ((clock_mode == serial_port_pkg::CLK_AUTO & role_dce)
         | clock_mode == serial_port_pkg::CLK_INTERNAL);
   end
   always_ff @(posedge clk) begin
      want_oe_q <= want_oe_d;
   end
   // The span check includes both ends.
   assign rate_ok = rate_bps >= `RATE_MIN && rate_bps <= `RATE_MAX;
   sequence ind_up_run;
      (line_check_en && ind_i) [*8];
   endsequence
   sequence ind_down_run;
      (line_check_en && !ind_i) [*8];
   endsequence
   sequence check_off_run;
      !line_check_en ##1 !line_check_en;
   endsequence
   a_oe_by_mode: assert property (bclk_oe == want_oe_q)
      else $error("clock pin drive does not follow role and mode");
   a_clock_quiet: assert property (!bclk_oe [*3] |-> !bclk_o)
      else $error("bit clock moves while the pin is not driven");
   a_rate_take: assert property (rate_load && rate_ok |=>
      active_rate == $past(rate_bps) && !rate_reject)
      else $error("legal rate not taken");
   a_rate_refuse: assert property (rate_load && !rate_ok |=>
      rate_reject && $stable(active_rate))
      else $error("illegal rate not refused");
   a_rate_steady: assert property (!rate_load |=>
      !rate_reject && $stable(active_rate))
      else $error("rate changed without a load");
   a_line_up: assert property (ind_up_run |-> line_up_flag)
      else $error("line state misses a high indication");
   a_line_down: assert property (ind_down_run |-> !line_up_flag)
      else $error("line state misses a low indication");
   a_forced_up: assert property (check_off_run |-> line_up_flag)
      else $error("line state not up with checking off");
endmodule : serial_port_ctrl_assertions
bind serial_port_ctrl serial_port_ctrl_assertions chk (
   .clk, .reset_n, .role_dce, .clock_mode, .line_check_en, .rate_bps, .rate_load,
   .ind_i, .bclk_o, .bclk_oe, .active_rate, .rate_reject, .line_up_flag
);

/* File: far_end_model.sv */
// Behavioural far-end equipment: supplies the bit clock when it drives and echoes data.
`timescale 1ns/10ps
module far_end_model (
   input wire logic run,
   input wire logic bclk_oe,
   input wire logic bclk_o,
   input wire logic txd_i,
   output logic link_clk,
   output logic rxd_o
);
   logic pclk = 1'b0;
   // A 32 ns clock offset from the system clock; it stops low between frames.
   initial begin
      #5;
      forever begin
         #16;
         if (run || pclk) begin
            pclk = ~pclk;
         end
      end
   end
   // Whichever end drives owns the clock pin; echoed data therefore rides on that clock.
   assign link_clk = bclk_oe ? bclk_o : pclk;
   // The line rests at mark level outside frames, as a released line with pull-up would.
   assign rxd_o = run ? txd_i : 1'b1;
endmodule : far_end_model

/* File: serial_port_ctrl_tb_top.sv */
// Self-checking bench for the serial port control block.
`timescale 1ns/10ps
`include "serial_port_params.svh"
module serial_port_ctrl_tb_top;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic link_clk;
   logic role_dce = 1'b0;
   serial_port_pkg::clk_mode_t clock_mode = serial_port_pkg::CLK_AUTO;
   serial_port_pkg::l2_mode_t l2_mode = serial_port_pkg::L2_AUTO;
   logic line_check_en = 1'b0;
   logic [22:0] rate_bps = 23'h000000;
   logic rate_load = 1'b0;
   logic ind_i = 1'b1;
   logic rxd_i;
   logic bclk_o;
   logic bclk_oe;
   logic txd_o;
   logic tx_valid = 1'b0;
   serial_port_pkg::tx_word_t tx_word = '0;
   logic tx_ready;
   logic tx_busy;
   logic rx_valid;
   serial_port_pkg::rx_word_t rx_word;
   logic [22:0] active_rate;
   logic [22:0] exp_rate;
   logic rate_reject;
   logic line_up_flag;
   logic link_ready;
   logic run = 1'b0;
   int err_count = 0;
   int checks = 0;
   serial_port_pkg::rx_word_t rx_q[$];
   logic [22:0] rates[6] = '{23'h00095f, 23'h000960, 23'h7a1200, 23'h7a1201, 23'h000000,
      23'h00fa00};

   serial_port_ctrl uut (
      .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .role_dce(role_dce),
      .clock_mode(clock_mode), .l2_mode(l2_mode), .line_check_en(line_check_en),
      .rate_bps(rate_bps), .rate_load(rate_load), .ind_i(ind_i), .rxd_i(rxd_i),
      .bclk_o(bclk_o), .bclk_oe(bclk_oe), .txd_o(txd_o), .tx_valid(tx_valid),
      .tx_word(tx_word), .tx_ready(tx_ready), .tx_busy(tx_busy), .rx_valid(rx_valid),
      .rx_word(rx_word), .active_rate(active_rate), .rate_reject(rate_reject),
      .line_up_flag(line_up_flag), .link_ready(link_ready)
   );
   far_end_model partner (
      .run(run), .bclk_oe(bclk_oe), .bclk_o(bclk_o), .txd_i(txd_o), .link_clk(link_clk),
      .rxd_o(rxd_i)
   );

   // System clock, 40 ns period.
   always #20 clk = ~clk;

   // Received words are collected away from the rising edge so registered values are settled.
   always @(negedge clk) begin
      if (rx_valid === 1'b1) begin
         rx_q.push_back(rx_word);
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task end_sim;
      $display("comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   // One-cycle load pulse; the answer is looked at one cycle later.
   task load_rate(input logic [22:0] r);
      logic rej;
      rej = r < `RATE_MIN || r > `RATE_MAX;
      if (!rej) begin
         exp_rate = r;
      end
      @(negedge clk);
      rate_bps = r;
      rate_load = 1'b1;
      @(negedge clk);
      rate_load = 1'b0;
      check(rate_reject, rej);
      check(active_rate, exp_rate);
   endtask : load_rate

   task line_step(input logic en, input logic ind, input logic exp);
      @(negedge clk);
      line_check_en = en;
      ind_i = ind;
      repeat (10) @(negedge clk);
      check(line_up_flag, exp);
   endtask : line_step

   // One-byte frame; the echo returns the address byte first, then the data with eof.
   task send_frame(input logic [7:0] d, input logic [7:0] addr);
      int n;
      n = 0;
      rx_q.delete();
      @(negedge clk);
      run = 1'b1;
      tx_word = {1'b1, d};
      tx_valid = 1'b1;
      // The address word goes out first, so the user word is refused until it is acknowledged.
      @(negedge clk);
      check(tx_busy, 1'b1);
      check(tx_ready, 1'b0);
      while (tx_ready !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      tx_valid = 1'b0;
      while ((rx_q.size() < 2 || tx_busy !== 1'b0) && n < 20000) begin
         @(negedge clk);
         n++;
      end
      run = 1'b0;
      check(rx_q.size(), 2);
      if (rx_q.size() == 2) begin
         check(rx_q[0], {1'b0, addr});
         check(rx_q[1], {1'b1, d});
      end
   endtask : send_frame

   // Main sequence.
   initial begin
      int n;
      int cnt;
      logic prev;
      exp_rate = `RATE_DEF;
      repeat (5) @(negedge clk);
      check(active_rate, 23'h00fa00);
      check(line_up_flag, 1'b1);
      check(bclk_oe, 1'b0);
      reset_n = 1'b1;
      // The link domain needs running clock edges to leave its reset.
      run = 1'b1;
      n = 0;
      while (link_ready !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      run = 1'b0;
      check(link_ready, 1'b1);
      for (int i = 0; i < 6; i++) begin
         load_rate(rates[i]);
      end
      line_step(1'b1, 1'b0, 1'b0);
      line_step(1'b1, 1'b1, 1'b1);
      line_step(1'b0, 1'b0, 1'b1);
      clock_mode = serial_port_pkg::CLK_EXTERNAL;
      for (int i = 0; i < 4; i++) begin
         role_dce = i == 1 || i == 2;
         l2_mode = i < 2 ? serial_port_pkg::L2_AUTO :
            (i == 2 ? serial_port_pkg::L2_DTE : serial_port_pkg::L2_DCE);
         send_frame({5'h1f, i[2:0]}, i[0] ? `ADDR_DCE : `ADDR_DTE);
      end
      for (int r = 0; r < 2; r++) begin
         for (int m = 0; m < 3; m++) begin
            @(negedge clk);
            role_dce = r[0];
            clock_mode = serial_port_pkg::clk_mode_t'(m[1:0]);
            repeat (2) @(negedge clk);
            check(bclk_oe, m == 2 || (m == 0 && r == 1));
         end
      end
      // Internal mode at 64000 bps toggles 128000 times a second: 19 or 20 in 3906 cycles.
      prev = bclk_o;
      cnt = 0;
      repeat (3906) begin
         @(negedge clk);
         if (bclk_o !== prev) begin
            cnt++;
         end
         prev = bclk_o;
      end
      check(cnt >= 19 && cnt <= 20, 1'b1);
      end_sim();
   end

   // Watchdog, far beyond the few thousand cycles the tests need.
   initial begin
      #1000000;
      err_count++;
      end_sim();
   end
endmodule : serial_port_ctrl_tb_top
